// ---- srer_pkg.sv ----
// Package: register selects, bit positions and reset values for the stream read error report block
package srer_pkg;
  // Register selects on the command-block port
  localparam logic [3:0] REG_DATA = 4'h0;
  localparam logic [3:0] REG_ERROR = 4'h1;
  localparam logic [3:0] REG_FEATURE = 4'h1;
  localparam logic [3:0] REG_SECT_CNT = 4'h2;
  localparam logic [3:0] REG_LBA_B0_B3 = 4'h3;
  localparam logic [3:0] REG_LBA_B1_B4 = 4'h4;
  localparam logic [3:0] REG_LBA_B2_B5 = 4'h5;
  localparam logic [3:0] REG_DEV_HEAD = 4'h6;
  localparam logic [3:0] REG_STATUS = 4'h7;
  localparam logic [3:0] REG_COMMAND = 4'h7;
  localparam logic [3:0] REG_DEV_CTRL = 4'he;
  // Error register bit positions
  localparam int ERR_TLO_BIT = 0;
  localparam int ERR_ABRT_BIT = 2;
  localparam int ERR_IDNF_BIT = 4;
  localparam int ERR_UNC_BIT = 6;
  localparam int ERR_ICRC_BIT = 7;
  // Status register bit positions
  localparam int ST_ERR_BIT = 0;
  localparam int ST_SE_BIT = 5;
  localparam int ST_RDY_BIT = 6;
  localparam int ST_BSY_BIT = 7;
  // Feature and device control bit positions
  localparam int FEAT_CRM_BIT = 6;
  localparam int DCTL_HOB_BIT = 7;
  // Reset values and the zero-count transfer length
  localparam logic [7:0] STATUS_RST = 8'h40;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [16:0] ZERO_COUNT_LEN = 17'h10000;
  // Sequencer states
  typedef enum logic [1:0]
  {
    SRER_IDLE = 2'b00,
    SRER_RUN = 2'b01,
    SRER_POST = 2'b10,
    SRER_DONE = 2'b11
  } srer_state_t;
endpackage : srer_pkg

// ---- srer_pair_reg.sv ----
// Byte pair register: current and previous write copies of one command-block register
`timescale 1ns/1ps
`default_nettype none
module srer_pair_reg
#(
  parameter int W = 8
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wr,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] cur_ff,
  output logic [W-1:0] prev_ff
);
  // Each write shifts the old current byte into the previous slot
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur_ff <= '0;
      prev_ff <= '0;
    end
    else if (ce && wr)
    begin
      prev_ff <= cur_ff;
      cur_ff <= wdata;
    end
  end
endmodule : srer_pair_reg
`default_nettype wire

// ---- srer_result_reg.sv ----
// Result capture: holds the ending address, count, error and status, loaded in one cycle
`timescale 1ns/1ps
`default_nettype none
module srer_result_reg
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic load,
  input wire logic [47:0] lba_in,
  input wire logic [15:0] cnt_in,
  input wire logic [7:0] err_in,
  input wire logic [7:0] st_in,
  output logic [47:0] lba_ff,
  output logic [15:0] cnt_ff,
  output logic [7:0] err_ff,
  output logic [7:0] st_ff
);
  // All four values move together so the host never sees a mixed set
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lba_ff <= '0;
      cnt_ff <= '0;
      err_ff <= srer_pkg::ZERO_BYTE;
      st_ff <= srer_pkg::STATUS_RST;
    end
    else if (ce && load)
    begin
      lba_ff <= lba_in;
      cnt_ff <= cnt_in;
      err_ff <= err_in;
      st_ff <= st_in;
    end
  end
endmodule : srer_result_reg
`default_nettype wire

// ---- srer_top.sv ----
// Stream read error report: command-block registers, ending status and error address report
// Behaviour
// - Select clear returns error address low bytes
// - Select set returns error address high bytes
// - Time limit expiry sets error bit zero
// - Errors with continuous mode set stream flag
// - Reported address is first failing sector
// - Continuous mode count registers return suspect sector run
// - Continuous mode errors keep error bit clear
// - Continuous mode error type bits go to error log
// - Continuous mode runs full length until timeout
// - Zero sector count means 65536 sectors
`timescale 1ns/1ps
`default_nettype none
module srer_top
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Command-block register port, same clock domain
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_sel,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Media engine side
  output logic xfer_start,
  output logic [47:0] xfer_lba,
  output logic [16:0] xfer_len,
  output logic continuous_read_mode,
  input wire logic sector_done,
  input wire logic sector_bad,
  input wire logic err_icrc,
  input wire logic err_unc,
  input wire logic err_idnf,
  input wire logic err_abrt,
  input wire logic completion_time_limit,
  // Error log output
  output logic [7:0] err_log_ff,
  output logic err_log_wr,
  output logic busy
);
  logic rst_s1_ff;
  logic rst_n_ff;
  // Reset released through two flops; the first is read only by the second
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_s1_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= 1'b1;
      rst_n_ff <= rst_s1_ff;
    end
  end

  // Register write decode
  wire wr_en = clk_en && reg_wr;
  wire wr_feat = wr_en && reg_sel == srer_pkg::REG_FEATURE;
  wire wr_cnt = wr_en && reg_sel == srer_pkg::REG_SECT_CNT;
  wire wr_b0 = wr_en && reg_sel == srer_pkg::REG_LBA_B0_B3;
  wire wr_b1 = wr_en && reg_sel == srer_pkg::REG_LBA_B1_B4;
  wire wr_b2 = wr_en && reg_sel == srer_pkg::REG_LBA_B2_B5;
  wire wr_cmd = wr_en && reg_sel == srer_pkg::REG_COMMAND;
  wire wr_dctl = wr_en && reg_sel == srer_pkg::REG_DEV_CTRL;

  logic [7:0] feat_cur, feat_prev, cnt_cur, cnt_prev;
  logic [7:0] b0_cur, b3_prev, b1_cur, b4_prev, b2_cur, b5_prev;
  // Current write holds bytes 0..2, previous write bytes 3..5
  srer_pair_reg u_feat (.clk(ref_clk), .rst_n(rst_n_ff), .ce(clk_en), .wr(wr_feat), .wdata(reg_wdata),
    .cur_ff(feat_cur), .prev_ff(feat_prev));
  srer_pair_reg u_cnt (.clk(ref_clk), .rst_n(rst_n_ff), .ce(clk_en), .wr(wr_cnt), .wdata(reg_wdata),
    .cur_ff(cnt_cur), .prev_ff(cnt_prev));
  srer_pair_reg u_b0 (.clk(ref_clk), .rst_n(rst_n_ff), .ce(clk_en), .wr(wr_b0), .wdata(reg_wdata),
    .cur_ff(b0_cur), .prev_ff(b3_prev));
  srer_pair_reg u_b1 (.clk(ref_clk), .rst_n(rst_n_ff), .ce(clk_en), .wr(wr_b1), .wdata(reg_wdata),
    .cur_ff(b1_cur), .prev_ff(b4_prev));
  srer_pair_reg u_b2 (.clk(ref_clk), .rst_n(rst_n_ff), .ce(clk_en), .wr(wr_b2), .wdata(reg_wdata),
    .cur_ff(b2_cur), .prev_ff(b5_prev));

  logic hob_ff;
  // Device control write picks which half of the result is readable
  always_ff @(posedge ref_clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
      hob_ff <= 1'b0;
    else if (wr_dctl)
      hob_ff <= reg_wdata[srer_pkg::DCTL_HOB_BIT];
  end

  wire [47:0] cmd_lba = {b5_prev, b4_prev, b3_prev, b2_cur, b1_cur, b0_cur};
  wire [15:0] cmd_cnt = {cnt_prev, cnt_cur};
  // Zero count is a full 65536 sector request
  wire [16:0] cmd_len = (cmd_cnt == 16'h0000) ? srer_pkg::ZERO_COUNT_LEN : {1'b0, cmd_cnt};

  srer_pkg::srer_state_t state_ff, nxt_state;
  logic crm_ff;
  logic [47:0] cur_lba_ff;
  logic [16:0] left_ff;
  logic [47:0] first_bad_ff;
  logic [15:0] bad_run_ff;
  logic run_open_ff;
  logic any_err_ff;
  logic [7:0] err_acc_ff;

  wire running = state_ff == srer_pkg::SRER_RUN;
  wire start = wr_cmd && state_ff != srer_pkg::SRER_RUN && state_ff != srer_pkg::SRER_POST;
  wire [7:0] evt_bits = {err_icrc, err_unc, 1'b0, err_idnf, 1'b0, err_abrt, 1'b0, completion_time_limit};
  wire evt_any = running && (|evt_bits || (sector_done && sector_bad));
  wire last_sector = sector_done && left_ff == 17'h00001;
  // Continuous mode ignores media errors; only the time limit stops it before the last sector
  wire stop_err = crm_ff ? completion_time_limit : (|evt_bits);
  wire finish = running && (last_sector || stop_err);
  // Next suspect count; the result takes it so a bad last sector is not lost
  wire bad_step = sector_done && sector_bad && (run_open_ff || !any_err_ff);
  wire [15:0] bad_run_nxt = (bad_step && bad_run_ff != 16'hffff) ? bad_run_ff + 16'h1 : bad_run_ff;

  // Sequencer next state
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      srer_pkg::SRER_IDLE: if (start) nxt_state = srer_pkg::SRER_RUN;
      srer_pkg::SRER_RUN: if (finish) nxt_state = srer_pkg::SRER_POST;
      srer_pkg::SRER_POST: nxt_state = srer_pkg::SRER_DONE;
      srer_pkg::SRER_DONE: if (start) nxt_state = srer_pkg::SRER_RUN;
      default: nxt_state = srer_pkg::SRER_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
      state_ff <= srer_pkg::SRER_IDLE;
    else if (clk_en)
      state_ff <= nxt_state;
  end

  // Command capture and progress tracking
  always_ff @(posedge ref_clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      crm_ff <= 1'b0;
      cur_lba_ff <= '0;
      left_ff <= '0;
    end
    else if (clk_en)
    begin
      if (start)
      begin
        crm_ff <= feat_cur[srer_pkg::FEAT_CRM_BIT];
        cur_lba_ff <= cmd_lba;
        left_ff <= cmd_len;
      end
      else if (running && sector_done)
      begin
        cur_lba_ff <= cur_lba_ff + 48'h1;
        left_ff <= left_ff - 17'h1;
      end
    end
  end

  // First bad sector and the run of suspect sectors that starts with it
  always_ff @(posedge ref_clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      first_bad_ff <= '0;
      bad_run_ff <= '0;
      run_open_ff <= 1'b0;
      any_err_ff <= 1'b0;
      err_acc_ff <= srer_pkg::ZERO_BYTE;
    end
    else if (clk_en)
    begin
      if (start)
      begin
        first_bad_ff <= '0;
        bad_run_ff <= '0;
        run_open_ff <= 1'b0;
        any_err_ff <= 1'b0;
        err_acc_ff <= srer_pkg::ZERO_BYTE;
      end
      else if (running)
      begin
        err_acc_ff <= err_acc_ff | evt_bits;
        if (evt_any)
          any_err_ff <= 1'b1;
        if (evt_any && !any_err_ff)
          first_bad_ff <= cur_lba_ff;
        // Counter saturates; a longer run still reads as the maximum
        if (bad_step)
        begin
          run_open_ff <= 1'b1;
          bad_run_ff <= bad_run_nxt;
        end
        else if (sector_done)
          run_open_ff <= 1'b0;
      end
    end
  end

  // Ending values; continuous mode hides the error type in the error register
  wire se_end = crm_ff && (any_err_ff || evt_any);
  wire [7:0] err_final = err_acc_ff | (running ? evt_bits : 8'h00);
  wire [7:0] err_end = crm_ff ? {7'h00, err_final[srer_pkg::ERR_TLO_BIT]} : err_final;
  wire err_bit_end = !crm_ff && (|err_final);
  wire [7:0] st_end = {1'b0, 1'b1, se_end, 4'h0, err_bit_end};
  // An error first seen on the finishing cycle is the current sector, not the stale capture
  wire [47:0] lba_end = (se_end && any_err_ff) ? first_bad_ff : cur_lba_ff;
  wire [15:0] cnt_end = se_end ? bad_run_nxt : 16'h0000;

  logic [47:0] res_lba;
  logic [15:0] res_cnt;
  logic [7:0] res_err, res_st;
  // Results load on the finishing cycle, one cycle before busy drops
  srer_result_reg u_res (.clk(ref_clk), .rst_n(rst_n_ff), .ce(clk_en), .load(finish),
    .lba_in(lba_end), .cnt_in(cnt_end), .err_in(err_end), .st_in(st_end),
    .lba_ff(res_lba), .cnt_ff(res_cnt), .err_ff(res_err), .st_ff(res_st));

  // Error log receives the full type bits in continuous mode
  always_ff @(posedge ref_clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      err_log_ff <= srer_pkg::ZERO_BYTE;
      err_log_wr <= 1'b0;
    end
    else if (clk_en)
    begin
      err_log_wr <= finish && se_end;
      if (finish && se_end)
        err_log_ff <= err_final;
    end
  end

  // Busy covers run and post, so status never shows stale values
  assign busy = running || state_ff == srer_pkg::SRER_POST;
  assign xfer_start = start;
  assign xfer_lba = cmd_lba;
  assign xfer_len = cmd_len;
  assign continuous_read_mode = crm_ff;

  // Read mux; the select chooses low or high address half
  wire [7:0] st_live = busy ? {1'b1, 7'h00} : res_st;
  wire [7:0] rd_b0 = hob_ff ? res_lba[31:24] : res_lba[7:0];
  wire [7:0] rd_b1 = hob_ff ? res_lba[39:32] : res_lba[15:8];
  wire [7:0] rd_b2 = hob_ff ? res_lba[47:40] : res_lba[23:16];
  wire [7:0] rd_cnt = hob_ff ? res_cnt[15:8] : res_cnt[7:0];
  always_comb
  begin
    case (reg_sel)
      srer_pkg::REG_ERROR: reg_rdata = res_err;
      srer_pkg::REG_SECT_CNT: reg_rdata = rd_cnt;
      srer_pkg::REG_LBA_B0_B3: reg_rdata = rd_b0;
      srer_pkg::REG_LBA_B1_B4: reg_rdata = rd_b1;
      srer_pkg::REG_LBA_B2_B5: reg_rdata = rd_b2;
      srer_pkg::REG_STATUS: reg_rdata = st_live;
      default: reg_rdata = 8'h00;
    endcase
  end

  // Checks
  a_hob_high_half: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    (hob_ff && reg_sel == srer_pkg::REG_LBA_B2_B5) |-> reg_rdata == res_lba[47:40])
    else $error("high half not shown");
  a_hob_low_half: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    (!hob_ff && reg_sel == srer_pkg::REG_LBA_B0_B3) |-> reg_rdata == res_lba[7:0])
    else $error("low half not shown");
  a_crm_err_clear: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    (clk_en && finish && crm_ff) |=> !res_st[srer_pkg::ST_ERR_BIT])
    else $error("error bit set in continuous mode");
  a_se_on_error: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    (clk_en && finish && crm_ff && (any_err_ff || evt_any)) |=> res_st[srer_pkg::ST_SE_BIT])
    else $error("stream flag missing");
  a_tlo_reported: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    (clk_en && finish && completion_time_limit) |=> res_err[srer_pkg::ERR_TLO_BIT])
    else $error("time limit flag missing");
  a_log_types: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    (clk_en && finish && se_end && err_unc) |=> err_log_wr && err_log_ff[srer_pkg::ERR_UNC_BIT])
    else $error("log misses error type");
  a_first_addr: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    (clk_en && finish && se_end) |=> res_lba == first_bad_ff)
    else $error("wrong error address");
  a_zero_count: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    (clk_en && start && cmd_cnt == 16'h0000) |=> left_ff == 17'h10000)
    else $error("zero count not full length");
  a_busy_order: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    (clk_en && finish) |=> busy ##1 (!clk_en || !busy))
    else $error("busy dropped early");
  a_crm_no_stop: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    (running && crm_ff && err_unc && !completion_time_limit && !last_sector) |-> !finish)
    else $error("continuous mode stopped on error");
  a_count_run: assert property (@(posedge ref_clk) disable iff (!rst_n_ff)
    (clk_en && finish && se_end) |=> res_cnt == bad_run_ff)
    else $error("suspect count wrong");
endmodule : srer_top
`default_nettype wire

// ---- srer_media_model.sv ----
// Media engine model: plays sectors back after each transfer start
`timescale 1ns/1ps
`default_nettype none
module srer_media_model
(
  input wire logic clk,
  input wire logic xfer_start,
  input wire logic [16:0] xfer_len,
  input wire logic busy,
  input wire logic [7:0] bad_lo,
  input wire logic [7:0] bad_hi,
  input wire logic [1:0] err_sel,
  input wire logic [7:0] tlo_at,
  output logic sector_done,
  output logic sector_bad,
  output logic [3:0] err_v,
  output logic tlo,
  output logic [16:0] sent
);
  logic go = 1'b0;
  logic run = 1'b0;
  logic ph = 1'b0;
  logic hit;
  logic [16:0] len;
  initial
  begin
    {sector_done, sector_bad, err_v, tlo, sent} = '0;
  end
  // Take the request at the edge the block launches it
  always @(posedge clk)
  begin
    if (xfer_start)
    begin
      go = 1'b1;
      len = xfer_len;
    end
  end
  // One sector every second cycle, away from the sampling edge
  always @(negedge clk)
  begin
    {sector_done, sector_bad, err_v, tlo} <= '0;
    if (go)
    begin
      go = 1'b0;
      run = 1'b1;
      ph = 1'b0;
      sent = '0;
    end
    else if (run && !busy)
      run = 1'b0; // Block stopped early, so does the engine
    else if (run)
    begin
      ph = ~ph;
      hit = (sent[7:0] >= bad_lo) && (sent[7:0] <= bad_hi);
      if (ph && tlo_at != 8'h00 && sent[7:0] == tlo_at)
      begin
        tlo <= 1'b1;
        run = 1'b0;
      end
      else if (ph)
      begin
        sector_done <= 1'b1;
        sector_bad <= hit;
        err_v[err_sel] <= hit;
        sent = sent + 17'h00001;
        if (sent == len)
          run = 1'b0;
      end
    end
  end
endmodule : srer_media_model
`default_nettype wire

// ---- testbench.sv ----
// Testbench: drives the command-block port and judges the ending report
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] reg_sel = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] bad_lo = 8'hff;
  logic [7:0] bad_hi = 8'h00;
  logic [1:0] err_sel = 2'h0;
  logic [7:0] tlo_at = 8'h00;
  logic [7:0] log_seen = 8'h00;
  wire [7:0] reg_rdata, err_log_ff;
  wire [47:0] xfer_lba;
  wire [16:0] xfer_len, sent;
  wire [3:0] err_v;
  wire xfer_start, continuous_read_mode, sector_done, sector_bad, tlo, err_log_wr, busy;
  int mismatches = 0;
  int checked = 0;
  srer_top dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .xfer_start(xfer_start),
    .xfer_lba(xfer_lba), .xfer_len(xfer_len), .continuous_read_mode(continuous_read_mode),
    .sector_done(sector_done), .sector_bad(sector_bad), .err_icrc(err_v[0]), .err_unc(err_v[1]),
    .err_idnf(err_v[2]), .err_abrt(err_v[3]), .completion_time_limit(tlo), .err_log_ff(err_log_ff),
    .err_log_wr(err_log_wr), .busy(busy));
  srer_media_model media_u (.clk(ref_clk), .xfer_start(xfer_start), .xfer_len(xfer_len), .busy(busy),
    .bad_lo(bad_lo), .bad_hi(bad_hi), .err_sel(err_sel), .tlo_at(tlo_at), .sector_done(sector_done),
    .sector_bad(sector_bad), .err_v(err_v), .tlo(tlo), .sent(sent));
  initial
  begin
    forever #50 ref_clk = ~ref_clk;
  end
  // Log byte is taken in the cycle of its write pulse
  always @(posedge ref_clk)
  begin
    if (err_log_wr === 1'b1)
      log_seen <= err_log_ff;
  end
  task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] sel, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_sel = sel;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] sel, output logic [7:0] v);
    @(negedge ref_clk);
    reg_sel = sel;
    reg_rd = 1'b1;
    #1;
    v = reg_rdata;
    @(negedge ref_clk);
    reg_rd = 1'b0;
  endtask : rd
  // Previous byte goes first, since each write pushes current into previous
  task automatic cmd(input logic [47:0] lba, input logic [15:0] cnt, input logic crm);
    logic [7:0] feat;
    feat = 8'h00;
    feat[srer_pkg::FEAT_CRM_BIT] = crm;
    for (int i = 0; i < 3; i++)
    begin
      wr(4'(srer_pkg::REG_LBA_B0_B3 + i), lba[24+8*i +: 8]);
      wr(4'(srer_pkg::REG_LBA_B0_B3 + i), lba[8*i +: 8]);
    end
    wr(srer_pkg::REG_SECT_CNT, cnt[15:8]);
    wr(srer_pkg::REG_SECT_CNT, cnt[7:0]);
    wr(srer_pkg::REG_FEATURE, 8'h00);
    wr(srer_pkg::REG_FEATURE, feat);
    log_seen = 8'h00;
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_sel = srer_pkg::REG_COMMAND;
    reg_wdata = 8'h2b;
    #1;
    chk("start", xfer_start, 1);
    chk("lba", xfer_lba, lba);
    chk("len", xfer_len, cnt == 16'h0000 ? 17'h10000 : {1'b0, cnt});
    @(negedge ref_clk);
    reg_wr = 1'b0;
    chk("mode", continuous_read_mode, crm);
  endtask : cmd
  // A second command while busy must not launch anything
  task automatic finish(output logic [7:0] st);
    int n;
    n = 0;
    @(negedge ref_clk);
    reg_wr = 1'b1;
    #1;
    chk("refused", xfer_start, 0);
    chk("busy", reg_rdata[srer_pkg::ST_BSY_BIT], 1);
    @(negedge ref_clk);
    reg_wr = 1'b0;
    while (busy !== 1'b0 && n < 3000)
    begin
      @(negedge ref_clk);
      n++;
    end
    st = reg_rdata;
    chk("done", n < 3000, 1);
  endtask : finish
  task automatic s_reset;
    logic [7:0] v;
    chk("busy", busy, 0);
    rd(srer_pkg::REG_STATUS, v);
    chk("status", v, srer_pkg::STATUS_RST);
    rd(srer_pkg::REG_ERROR, v);
    chk("error", v, 8'h00);
    // A command written while the enable is low must launch nothing
    clk_en = 1'b0;
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_sel = srer_pkg::REG_COMMAND;
    #1;
    chk("frozen", xfer_start, 0);
    @(negedge ref_clk);
    reg_wr = 1'b0;
    clk_en = 1'b1;
    chk("idle", busy, 0);
  endtask : s_reset
  task automatic s_zero_count;
    logic [7:0] v;
    bad_lo = 8'h00;
    bad_hi = 8'h00;
    err_sel = 2'h1;
    cmd(48'h0102_0304_0506, 16'h0000, 1'b0);
    finish(v);
    chk("status", v, 8'h41);
    rd(srer_pkg::REG_ERROR, v);
    chk("error", v, 8'h40);
  endtask : s_zero_count
  task automatic s_stream(input int et);
    logic [7:0] v;
    logic [47:0] a;
    int pos[4] = '{srer_pkg::ERR_ICRC_BIT, srer_pkg::ERR_UNC_BIT, srer_pkg::ERR_IDNF_BIT, srer_pkg::ERR_ABRT_BIT};
    a = 48'h8a9b_acbd_cedf;
    bad_lo = 8'h02;
    bad_hi = 8'h03;
    err_sel = 2'(et);
    cmd(a, 16'h0006, 1'b1);
    finish(v);
    chk("status", v, 8'h60);
    rd(srer_pkg::REG_ERROR, v);
    chk("error", v, 8'h00);
    chk("log", log_seen, 48'h1 << pos[et]);
    chk("sent", sent, 6);
    a = a + 48'h2;
    for (int h = 0; h < 2; h++)
    begin
      wr(srer_pkg::REG_DEV_CTRL, h == 1 ? 8'h80 : 8'h00);
      for (int i = 0; i < 3; i++)
      begin
        rd(4'(srer_pkg::REG_LBA_B0_B3 + i), v);
        chk("addr", v, a[24*h+8*i +: 8]);
      end
      rd(srer_pkg::REG_SECT_CNT, v);
      chk("count", v, h == 1 ? 8'h00 : 8'h02);
    end
    wr(srer_pkg::REG_DEV_CTRL, 8'h00);
  endtask : s_stream
  task automatic s_timeout;
    logic [7:0] v;
    bad_lo = 8'hff;
    bad_hi = 8'h00;
    tlo_at = 8'h03;
    cmd(48'h0000_1000_2000, 16'h0008, 1'b1);
    finish(v);
    chk("status", v, 8'h60);
    rd(srer_pkg::REG_ERROR, v);
    chk("error", v, 8'h01);
    chk("log", log_seen, 8'h01);
    chk("sent", sent, 3);
    // No bad sector before the limit: the stopping sector is reported, with an empty run
    rd(srer_pkg::REG_LBA_B0_B3, v);
    chk("addr", v, 8'h03);
    rd(srer_pkg::REG_SECT_CNT, v);
    chk("count", v, 8'h00);
    tlo_at = 8'h00;
  endtask : s_timeout
  task automatic report_and_stop;
    $display("Comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  // Watchdog: the whole run needs well under a thousand cycles
  initial
  begin
    #3000000;
    mismatches++;
    report_and_stop();
  end
  initial
  begin
    repeat (5) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    s_reset();
    s_zero_count();
    for (int et = 0; et < 4; et++)
      s_stream(et);
    s_timeout();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
